// ---- pmc_pkg.sv ----
// Constants and types for the period/position measuring counter.
// Assumes a single 125 MHz clock domain; no software-visible registers.
`default_nettype none
package pmc_pkg;
    // =========================================================
    // Clock and widths
    localparam int CLK_PERIOD_NS = 8;
    localparam int CNT_W         = 32;
    localparam int SYNC_STAGES   = 2;
    // =========================================================
    // Measurement modes
    typedef enum logic [2:0] {
        PMC_MODE_PERIOD,
        PMC_MODE_POS_SINGLE,
        PMC_MODE_POS_SAMPLED,
        PMC_MODE_FREQ_AVG
    } pmc_mode_t;
    // =========================================================
    // Position decoding
    typedef enum logic [1:0] {
        PMC_DEC_SINGLE_EDGE,
        PMC_DEC_DOUBLE_EDGE,
        PMC_DEC_FOUR_EDGE,
        PMC_DEC_TWO_PULSE
    } pmc_dec_t;
    localparam logic [CNT_W-1:0] PMC_CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] PMC_CNT_ONE  = 32'h0000_0001;
endpackage
`default_nettype wire

// ---- pmc_counter.sv ----
// Period, position and averaged-frequency measuring counter.
// Assumes all pin inputs except timebase_tick are asynchronous; software controls arrive as levels/pulses on clock.
// Function
// - Period measurement starts on the window input only after arming and ignores it before.
// - A setting picks rising-to-rising or falling-to-falling window edges for the period.
// - Count-input events between two active window edges are counted: timebase ticks, or external clock edges of the selected polarity.
// - The count input is either the internal timebase or an external known clock.
// - Position uses single, double or four-edge quadrature decoding or two-pulse encoders.
// - Position counting starts only once the counter is armed.
// - Position is read on demand or captured at each sample clock edge of the selected polarity.
// - Averaged frequency counts signal edges and timebase ticks over each sample period.
`default_nettype none
module pmc_counter
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire  logic             clock,
    input  wire  logic             reset,
    // Control
    input  wire  logic             arm,
    input  wire  logic             disarm,
    input  wire  pmc_pkg::pmc_mode_t mode,
    input  wire  pmc_pkg::pmc_dec_t  decode,
    input  wire  logic             window_fall,
    input  wire  logic             count_fall,
    input  wire  logic             use_ext_clk,
    input  wire  logic             sample_fall,
    input  wire  logic             read_req,
    // Pins
    input  wire  logic             window_pin,
    input  wire  logic             ext_clk_pin,
    input  wire  logic             timebase_tick,
    input  wire  logic             enc_a_pin,
    input  wire  logic             enc_b_pin,
    input  wire  logic             sample_pin,
    // Results
    output logic                   armed,
    output logic [pmc_pkg::CNT_W-1:0] result,
    output logic [pmc_pkg::CNT_W-1:0] result_aux,
    output logic                   result_valid
);
    import pmc_pkg::*;

    // =========================================================
    // State
    typedef struct packed {
        logic [1:0]       win_s, ext_s, a_s, b_s, smp_s;
        logic             win_d, ext_d, a_d, b_d, smp_d;
        logic             armed;
        logic             started;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cnt2;
        logic [CNT_W-1:0] res;
        logic [CNT_W-1:0] res2;
        logic             vld;
    } pmc_state_t;

    pmc_state_t st_r, st_nxt;

    function automatic logic edge_sel(input logic cur, input logic prv, input logic fall);
        edge_sel = fall ? (prv & ~cur) : (cur & ~prv);
    endfunction

    logic win, ext, qa, qb, smp;
    logic win_edge, src_edge, sig_edge, smp_edge, any_a, any_b, step, dir_up;

    always_comb begin
        st_nxt = st_r;
        // Second stage only feeds logic; first stage is read by nothing else
        win = st_r.win_s[1];
        ext = st_r.ext_s[1];
        qa  = st_r.a_s[1];
        qb  = st_r.b_s[1];
        smp = st_r.smp_s[1];
        st_nxt.win_s = {st_r.win_s[0], window_pin};
        st_nxt.ext_s = {st_r.ext_s[0], ext_clk_pin};
        st_nxt.a_s   = {st_r.a_s[0], enc_a_pin};
        st_nxt.b_s   = {st_r.b_s[0], enc_b_pin};
        st_nxt.smp_s = {st_r.smp_s[0], sample_pin};
        st_nxt.win_d = win;
        st_nxt.ext_d = ext;
        st_nxt.a_d   = qa;
        st_nxt.b_d   = qb;
        st_nxt.smp_d = smp;
        st_nxt.vld   = 1'b0;

        win_edge = edge_sel(win, st_r.win_d, window_fall);
        // Timebase tick is on-chip and already synchronous
        sig_edge = edge_sel(ext, st_r.ext_d, count_fall);
        src_edge = use_ext_clk ? sig_edge : timebase_tick;
        smp_edge = edge_sel(smp, st_r.smp_d, sample_fall);
        any_a    = qa ^ st_r.a_d;
        any_b    = qb ^ st_r.b_d;

        // Quadrature direction: A leads B counts up
        step   = 1'b0;
        dir_up = 1'b1;
        case (decode)
            PMC_DEC_SINGLE_EDGE: begin
                step   = any_a & (qa ? ~qb : ~qb);
                dir_up = qa;
            end
            PMC_DEC_DOUBLE_EDGE: begin
                step   = any_a;
                dir_up = qa ^ qb;
            end
            PMC_DEC_FOUR_EDGE: begin
                step   = any_a ^ any_b;
                dir_up = any_a ? (qa ^ qb) : ~(qa ^ qb);
            end
            PMC_DEC_TWO_PULSE: begin
                step   = (qa & ~st_r.a_d) ^ (qb & ~st_r.b_d);
                dir_up = qa & ~st_r.a_d;
            end
            default: begin
                step   = 1'b0;
                dir_up = 1'b1;
            end
        endcase

        if (arm) begin
            st_nxt.armed   = 1'b1;
            st_nxt.started = 1'b0;
            st_nxt.cnt     = PMC_CNT_ZERO;
            st_nxt.cnt2    = PMC_CNT_ZERO;
        end else if (disarm) begin
            st_nxt.armed   = 1'b0;
            st_nxt.started = 1'b0;
        end else if (st_r.armed) begin
            case (mode)
                PMC_MODE_PERIOD: begin
                    if (win_edge) begin
                        st_nxt.started = 1'b1;
                        st_nxt.cnt     = PMC_CNT_ZERO;
                        if (st_r.started) begin
                            st_nxt.res = st_r.cnt + (src_edge ? PMC_CNT_ONE : PMC_CNT_ZERO);
                            st_nxt.vld = 1'b1;
                        end
                    end else if (st_r.started && src_edge) begin
                        st_nxt.cnt = st_r.cnt + PMC_CNT_ONE;
                    end
                end
                PMC_MODE_POS_SINGLE, PMC_MODE_POS_SAMPLED: begin
                    if (step) begin
                        st_nxt.cnt = dir_up ? st_r.cnt + PMC_CNT_ONE : st_r.cnt - PMC_CNT_ONE;
                    end
                    // Sample clock never clears the cumulative position
                    if ((mode == PMC_MODE_POS_SAMPLED) ? smp_edge : read_req) begin
                        st_nxt.res = st_r.cnt;
                        st_nxt.vld = 1'b1;
                    end
                end
                PMC_MODE_FREQ_AVG: begin
                    // Too slow a signal gives zero edges per window: caller's duty
                    if (smp_edge) begin
                        // Coincident tick and edge close this window, else both are lost
                        st_nxt.res  = st_r.cnt + (timebase_tick ? PMC_CNT_ONE : PMC_CNT_ZERO);
                        st_nxt.res2 = st_r.cnt2 + (sig_edge ? PMC_CNT_ONE : PMC_CNT_ZERO);
                        st_nxt.vld  = 1'b1;
                        st_nxt.cnt  = PMC_CNT_ZERO;
                        st_nxt.cnt2 = PMC_CNT_ZERO;
                    end else begin
                        if (timebase_tick) st_nxt.cnt = st_r.cnt + PMC_CNT_ONE;
                        if (sig_edge) begin
                            st_nxt.cnt2 = st_r.cnt2 + PMC_CNT_ONE;
                        end
                    end
                end
                default: st_nxt.started = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) st_r <= '0;
        else       st_r <= st_nxt;
    end

    assign armed        = st_r.armed;
    assign result       = st_r.res;
    assign result_aux   = st_r.res2;
    assign result_valid = st_r.vld;

    // =========================================================
    // Checks
    property p_unarmed_quiet;
        @(posedge clock) disable iff (reset) !st_r.armed && !arm |=> !result_valid;
    endproperty
    a_unarmed_quiet: assert property (p_unarmed_quiet)
        else $error("result while unarmed");

    property p_period_restart;
        @(posedge clock) disable iff (reset)
            st_r.armed && !arm && !disarm && mode == PMC_MODE_PERIOD && win_edge |=> st_r.cnt == '0;
    endproperty
    a_period_restart: assert property (p_period_restart)
        else $error("period not restarted");

    property p_period_count;
        @(posedge clock) disable iff (reset)
            st_r.armed && !arm && !disarm && mode == PMC_MODE_PERIOD && st_r.started
            && !win_edge && src_edge |=> st_r.cnt == $past(st_r.cnt) + 1;
    endproperty
    a_period_count: assert property (p_period_count)
        else $error("source edge lost");

    property p_pos_sample;
        @(posedge clock) disable iff (reset)
            st_r.armed && !arm && !disarm && mode == PMC_MODE_POS_SAMPLED && smp_edge
            |=> result_valid && result == $past(st_r.cnt);
    endproperty
    a_pos_sample: assert property (p_pos_sample)
        else $error("position not captured");

    property p_arm_clear;
        @(posedge clock) disable iff (reset)
            arm |=> st_r.armed && !st_r.started && st_r.cnt == '0 && st_r.cnt2 == '0;
    endproperty
    a_arm_clear: assert property (p_arm_clear)
        else $error("arm did not clear the counts");

    // Unarmed counts must hold, whatever the pins do
    property p_unarmed_hold;
        @(posedge clock) disable iff (reset)
            !st_r.armed && !arm |=> $stable(st_r.cnt);
    endproperty
    a_unarmed_hold: assert property (p_unarmed_hold)
        else $error("count moved while unarmed");

    property p_freq_window;
        @(posedge clock) disable iff (reset)
            st_r.armed && !arm && !disarm && mode == PMC_MODE_FREQ_AVG && smp_edge
            |=> result_valid && st_r.cnt == '0 && st_r.cnt2 == '0
                && result_aux == $past(st_r.cnt2) + 32'($past(sig_edge));
    endproperty
    a_freq_window: assert property (p_freq_window)
        else $error("frequency window not closed");
endmodule
`default_nettype wire

// ---- pmc_src_model.sv ----
// Far side: a square gate wave and an external clock of known period.
// Assumes the bench clock; pins move on falling edges, and both stand still while run is low.
`default_nettype none
module pmc_src_model #(
    parameter int HALF_W = 12,
    parameter int HALF_E = 4
) (
    // Timing
    input  wire logic clock,
    input  wire logic run,
    // Pins
    output var logic  window_pin,
    output var logic  ext_clk_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cw = 0;
    int ce = 0;
    initial window_pin = 1'b0;
    initial ext_clk_pin = 1'b0;
    // =========================================================
    // Gate edges at least twelve clocks apart, well above the sync limit
    // Gate doubles as sample clock; HALF_W >= 2 * HALF_E keeps the signal fast enough
    always @(negedge clock) begin
        if (run) begin
            cw = (cw + 1) % HALF_W;
            ce = (ce + 1) % HALF_E;
            if (cw == 0) window_pin <= ~window_pin;
            if (ce == 0) ext_clk_pin <= ~ext_clk_pin;
        end
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Bench for the measuring counter: period, external clock, arming, position.
// Assumes pmc_pkg and pmc_src_model compiled first; one 125 MHz clock.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmc_pkg::*;
    logic             clock = 1'b0, reset = 1'b1, arm = 1'b0, disarm = 1'b0, read_req = 1'b0;
    logic             window_fall = 1'b0, count_fall = 1'b0, use_ext_clk = 1'b0, run = 1'b0;
    logic             tick = 1'b0;
    logic             enc_a = 1'b0, enc_b = 1'b0, window_pin, ext_clk_pin, armed, result_valid;
    pmc_mode_t        mode = PMC_MODE_PERIOD;
    pmc_dec_t         decode = PMC_DEC_SINGLE_EDGE;
    logic [CNT_W-1:0] result, result_aux;
    int               errors = 0, cmp_count = 0;
    always #4 clock = ~clock;
    // Timebase ticks every other cycle, so ticks and cycles differ
    always @(negedge clock) tick <= ~tick;
    pmc_src_model #(.HALF_W(12), .HALF_E(4)) src (.clock(clock), .run(run),
        .window_pin(window_pin), .ext_clk_pin(ext_clk_pin));
    pmc_counter uut (.clock(clock), .reset(reset), .arm(arm), .disarm(disarm), .mode(mode),
        .decode(decode), .window_fall(window_fall), .count_fall(count_fall),
        .use_ext_clk(use_ext_clk), .sample_fall(window_fall), .read_req(read_req),
        .window_pin(window_pin), .ext_clk_pin(ext_clk_pin), .timebase_tick(tick),
        .enc_a_pin(enc_a), .enc_b_pin(enc_b), .sample_pin(window_pin), .armed(armed),
        .result(result), .result_aux(result_aux), .result_valid(result_valid));
    // =========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_arm();
        @(negedge clock) arm = 1'b1;
        @(negedge clock) arm = 1'b0;
        @(negedge clock) chk("armed", 32'(armed), 32'h1);
    endtask
    // Bounded wait; the valid pulse stands one cycle only
    task automatic wait_valid(output logic [31:0] r);
        int n;
        n = 0;
        r = 'x;
        while (n < 200) begin
            @(posedge clock) #1;
            if (result_valid === 1'b1) begin
                r = result;
                n = 1000;
            end
            n++;
        end
        if (n < 1000) chk("valid", 32'h0, 32'h1);
    endtask
    task automatic step(input logic a, input logic b);
        @(negedge clock) begin
            enc_a = a;
            enc_b = b;
        end
        repeat (3) @(negedge clock);
    endtask
    // Two full quadrature turns with A leading
    task automatic two_turns();
        repeat (2) begin
            step(1'b1, 1'b0);
            step(1'b1, 1'b1);
            step(1'b0, 1'b1);
            step(1'b0, 1'b0);
        end
    endtask
    // =========================================================
    // Scenarios
    task automatic t_period();
        logic [31:0] r;
        for (int k = 0; k < 4; k++) begin
            @(negedge clock) begin
                use_ext_clk = k[1];
                window_fall = k[0];
                count_fall = k[0];
                run = 1'b1;
            end
            do_arm();
            wait_valid(r);
            chk("period", r, k[1] ? 32'h3 : 32'hC);
            wait_valid(r);
            chk("restart", r, k[1] ? 32'h3 : 32'hC);
        end
    endtask
    task automatic t_idle();
        int seen;
        seen = 0;
        @(negedge clock) disarm = 1'b1;
        @(negedge clock) disarm = 1'b0;
        repeat (100) begin
            @(posedge clock) #1;
            if (result_valid !== 1'b0) seen++;
        end
        chk("idle", 32'(seen), 32'h0);
        chk("disarmed", 32'(armed), 32'h0);
        // Reset in mid-run clears the held result
        @(negedge clock) reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        chk("reset result", result, 32'h0);
        chk("reset armed", 32'(armed), 32'h0);
    endtask
    task automatic t_pos();
        logic [31:0] r;
        logic [31:0] exp [4] = '{32'h2, 32'h4, 32'h8, 32'h0};
        @(negedge clock) run = 1'b0;
        for (int d = 0; d < 4; d++) begin
            @(negedge clock) begin
                mode = PMC_MODE_POS_SINGLE;
                decode = pmc_dec_t'(d);
            end
            do_arm();
            two_turns();
            @(negedge clock) begin
                read_req = 1'b1;
                read_req <= #8 1'b0;
            end
            wait_valid(r);
            chk("position", r, exp[d]);
        end
    endtask
    task automatic t_sampled();
        logic [31:0] r;
        @(negedge clock) begin
            mode = PMC_MODE_POS_SAMPLED;
            decode = PMC_DEC_FOUR_EDGE;
            window_fall = 1'b0;
        end
        do_arm();
        two_turns();
        @(negedge clock) run = 1'b1;
        wait_valid(r);
        chk("sampled", r, 32'h8);
        @(negedge clock) run = 1'b0;
        // One turn with B leading counts back down
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        @(negedge clock) run = 1'b1;
        wait_valid(r);
        chk("cumulative", r, 32'h4);
    endtask
    // First window after arm is partial and is skipped
    task automatic t_freq();
        logic [31:0] r;
        for (int f = 0; f < 2; f++) begin
            @(negedge clock) begin
                mode = PMC_MODE_FREQ_AVG;
                window_fall = f[0];
                count_fall = f[0];
            end
            do_arm();
            wait_valid(r);
            wait_valid(r);
            chk("timebase", r, 32'hC);
            chk("signal", result_aux, 32'h3);
        end
    endtask
    initial begin
        repeat (16) @(negedge clock);
        reset = 1'b0;
        t_period();
        t_idle();
        t_pos();
        t_sampled();
        t_freq();
        complete_run();
    end
    // Roughly ten times the expected run length
    initial begin
        #60000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
